// *** shared/opdrv_pkg.sv ***
// opdrv_pkg: types of the output-driver power control bank.
// assumes nothing; compiled before any design file.
package opdrv_pkg;

  // headphone output common-mode level
  typedef enum logic [1:0] {
    opdrv_cm_1v35,
    opdrv_cm_1v50,
    opdrv_cm_1v65,
    opdrv_cm_1v80
  } opdrv_cm_type;

  // one register byte
  typedef logic [7:0] opdrv_byte_type;

endpackage

// *** shared/opdrv_regs.svh ***
// opdrv_regs.svh: offsets, field positions and reset values of the
// output-driver power control bank (page 1, registers 0 and 30..32).
// assumes it is included by its bare name from any design file.
`ifndef OPDRV_REGS_SVH
`define OPDRV_REGS_SVH

// register offsets within a page
`define OPDRV_PAGE_OFS 8'h00
`define OPDRV_RSVD_FIRST 8'h01
`define OPDRV_RSVD_LAST 8'h1d
`define OPDRV_ERR_OFS 8'h1e
`define OPDRV_HP_OFS 8'h1f
`define OPDRV_SPK_OFS 8'h20

// page that holds the driver registers
`define OPDRV_DRV_PAGE 8'h01

// reset values
`define OPDRV_PAGE_RST 8'h00
`define OPDRV_ERR_RST 8'h00
`define OPDRV_HP_RST 8'h04
`define OPDRV_SPK_RST 8'h06
`define OPDRV_RD_ZERO 8'h00

// amp short handling fields
`define OPDRV_SPK_KEEP_BIT 1
`define OPDRV_HP_KEEP_BIT 0

// headphone driver fields
`define OPDRV_HPL_BIT 7
`define OPDRV_HPR_BIT 6
`define OPDRV_CM_MSB 4
`define OPDRV_CM_LSB 3
`define OPDRV_HP_PDN_BIT 1

// speaker driver fields
`define OPDRV_SPK_PWR_BIT 7

// live short flag position, shared by both driver registers
`define OPDRV_FLAG_BIT 0

// masks that drop the power-up bits on an automatic clear
`define OPDRV_HP_CLR_MASK 8'h3f
`define OPDRV_SPK_CLR_MASK 8'h7f

`endif

// *** sim/opdrv_host_model.sv ***
// opdrv_host_model: behavioural serial-control host on the byte port.
// assumes the bank samples requests on the rising core_clk edge.
`timescale 1ns/1ps
module opdrv_host_model (
  input wire logic core_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic [7:0] page;

  // idle bus at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    page = 8'h00;
  end

  // one write, held over one rising edge; reserved fields forced legal
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (page == 8'h01 && a >= 8'h01 && a <= 8'h1d)
      return;
    if (page == 8'h01 && a == 8'h1f) begin
      v[5] = 1'b0;
      v[2] = 1'b1;
    end
    if (page == 8'h01 && a == 8'h20)
      v[5:1] = 5'b00011;
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a; // released bus shows no stale value
    reg_wdata = ~v;
    if (a == 8'h00)
      page = v;
  endtask

  // one read; answer taken on the falling edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// *** sim/output_driver_power_ctrl_regs_bench.sv ***
// bench for the output-driver power control bank.
// assumes the host model drives the byte port; shorts driven here.
`timescale 1ns/1ps
module output_driver_power_ctrl_regs_bench;
  logic core_clk, resetn, hp_short_det, spk_short_det;
  logic reg_wr_en, reg_rd_en, reg_rvalid, hp_current_limit;
  logic left_headphone_driver_en, right_headphone_driver_en, spk_driver_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, page_sel;
  opdrv_pkg::opdrv_cm_type hp_cm_sel;
  int n_mismatch = 0;
  int tests_run = 0;

  opdrv_regbank uut (.core_clk(core_clk), .resetn(resetn),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .hp_short_det(hp_short_det), .spk_short_det(spk_short_det),
    .page_sel(page_sel), .left_headphone_driver_en(left_headphone_driver_en),
    .right_headphone_driver_en(right_headphone_driver_en),
    .spk_driver_en(spk_driver_en), .hp_cm_sel(hp_cm_sel),
    .hp_current_limit(hp_current_limit));

  opdrv_host_model host (.core_clk(core_clk), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // 125 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // read and compare data, rvalid too
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk({7'h00, v}, 8'h01, "rvalid");
    chk(d, exp, "rdata");
  endtask

  // headphone enables and current limit packed for one compare
  function automatic logic [7:0] hp_st();
    return {5'h00, hp_current_limit, left_headphone_driver_en,
            right_headphone_driver_en};
  endfunction

  // watchdog, far beyond the roughly 80 cycles of the tests
  initial begin
    #50000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  // test sequence
  initial begin
    resetn = 1'b0;
    hp_short_det = 1'b0;
    spk_short_det = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    chk(page_sel, 8'h00, "page reset");
    rchk(8'h00, 8'h00);
    host.wr(8'h00, 8'hff);
    chk(page_sel, 8'hff, "page ff");
    rchk(8'h1f, 8'h00);
    host.wr(8'h00, 8'h01);
    rchk(8'h1e, 8'h00);
    rchk(8'h1f, 8'h04);
    rchk(8'h20, 8'h06);
    rchk(8'h05, 8'h00);
    $display("test reset_page done");
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h1f, 8'hc4 | 8'(c << 3));
      chk({6'h00, hp_cm_sel}, 8'(c), "cm");
      rchk(8'h1f, 8'hc4 | 8'(c << 3));
    end
    host.wr(8'h1f, 8'h04);
    chk(hp_st(), 8'h00, "hp off");
    host.wr(8'h1f, 8'hc5);
    chk(hp_st(), 8'h03, "hp on");
    rchk(8'h1f, 8'hc4);
    $display("test hp_fields done");
    hp_short_det = 1'b1;
    @(negedge core_clk);
    chk(hp_st(), 8'h07, "limit");
    rchk(8'h1f, 8'hc5);
    hp_short_det = 1'b0;
    rchk(8'h1f, 8'hc4);
    host.wr(8'h1f, 8'hc6);
    hp_short_det = 1'b1;
    @(negedge core_clk);
    chk(hp_st(), 8'h00, "pdn");
    hp_short_det = 1'b0;
    @(negedge core_clk);
    chk(hp_st(), 8'h00, "stay off");
    rchk(8'h1f, 8'h06);
    host.wr(8'h1e, 8'h01);
    host.wr(8'h1f, 8'hc6);
    hp_short_det = 1'b1;
    @(negedge core_clk);
    chk(hp_st(), 8'h00, "keep pdn");
    hp_short_det = 1'b0;
    @(negedge core_clk);
    chk(hp_st(), 8'h03, "keep on");
    rchk(8'h1f, 8'hc6);
    $display("test hp_short done");
    host.wr(8'h20, 8'h86);
    chk({7'h00, spk_driver_en}, 8'h01, "spk on");
    rchk(8'h20, 8'h86);
    spk_short_det = 1'b1;
    @(negedge core_clk);
    chk({7'h00, spk_driver_en}, 8'h00, "spk clr");
    rchk(8'h20, 8'h07);
    spk_short_det = 1'b0;
    rchk(8'h20, 8'h06);
    host.wr(8'h1e, 8'h03);
    rchk(8'h1e, 8'h03);
    host.wr(8'h20, 8'h86);
    spk_short_det = 1'b1;
    @(negedge core_clk);
    chk({7'h00, spk_driver_en}, 8'h01, "spk keep");
    rchk(8'h20, 8'h87);
    spk_short_det = 1'b0;
    rchk(8'h20, 8'h86);
    $display("test spk_short done");
    print_verdict();
  end
endmodule

// *** src/opdrv_regbank.sv ***
// opdrv_regbank: page select and output-driver power control registers.
// assumes a serial-control front end presents one byte access per
// cycle on the reg_* port, synchronous to core_clk.
`timescale 1ns/1ps
`include "opdrv_regs.svh"
module opdrv_regbank (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic hp_short_det,
  input wire logic spk_short_det,
  output logic [7:0] page_sel,
  output logic left_headphone_driver_en,
  output logic right_headphone_driver_en,
  output logic spk_driver_en,
  output opdrv_pkg::opdrv_cm_type hp_cm_sel,
  output logic hp_current_limit
);

  // true when addr hits a driver register on the driver page
  function automatic logic drv_hit(input logic [7:0] pg,
                                   input logic [7:0] a,
                                   input logic [7:0] ofs);
    drv_hit = (pg == `OPDRV_DRV_PAGE) && (a == ofs);
  endfunction

  opdrv_pkg::opdrv_byte_type page_q, page_d;
  opdrv_pkg::opdrv_byte_type err_q, err_d;
  opdrv_pkg::opdrv_byte_type hp_q, hp_d;
  opdrv_pkg::opdrv_byte_type spk_q, spk_d;
  opdrv_pkg::opdrv_byte_type rdata_q, rdata_d;
  logic rvalid_q;
  logic wr_page, wr_err, wr_hp, wr_spk;
  logic rd_err, rd_hp, rd_spk, rd_page;
  logic hp_clr, spk_clr;
  logic [1:0] hp_drv_en;
  opdrv_pkg::opdrv_byte_type hp_wr_val, spk_wr_val;
  opdrv_pkg::opdrv_byte_type hp_rd_val, spk_rd_val;

  // address decode; page selector answers on any page
  assign wr_page = reg_wr_en && (reg_addr == `OPDRV_PAGE_OFS);
  assign wr_err = reg_wr_en && drv_hit(page_q, reg_addr, `OPDRV_ERR_OFS);
  assign wr_hp = reg_wr_en && drv_hit(page_q, reg_addr, `OPDRV_HP_OFS);
  assign wr_spk = reg_wr_en && drv_hit(page_q, reg_addr, `OPDRV_SPK_OFS);
  assign rd_page = reg_addr == `OPDRV_PAGE_OFS;
  assign rd_err = drv_hit(page_q, reg_addr, `OPDRV_ERR_OFS);
  assign rd_hp = drv_hit(page_q, reg_addr, `OPDRV_HP_OFS);
  assign rd_spk = drv_hit(page_q, reg_addr, `OPDRV_SPK_OFS);

  // short response: clears and gating
  opdrv_short_ctrl u_short (
    .hp_short_det(hp_short_det),
    .spk_short_det(spk_short_det),
    .hp_keep(err_q[`OPDRV_HP_KEEP_BIT]),
    .spk_keep(err_q[`OPDRV_SPK_KEEP_BIT]),
    .hp_pdn_mode(hp_q[`OPDRV_HP_PDN_BIT]),
    .hp_pwr({hp_q[`OPDRV_HPL_BIT], hp_q[`OPDRV_HPR_BIT]}),
    .spk_pwr(spk_q[`OPDRV_SPK_PWR_BIT]),
    .hp_clr(hp_clr),
    .spk_clr(spk_clr),
    .hp_drv_en(hp_drv_en),
    .spk_drv_en(spk_driver_en),
    .hp_current_limit(hp_current_limit)
  );

  // next values; flag bit 0 is never stored, a clear beats a write
  assign page_d = wr_page ? reg_wdata : page_q;
  assign err_d = wr_err ? reg_wdata : err_q;
  assign hp_wr_val = wr_hp ? {reg_wdata[7:1], 1'b0} : hp_q;
  assign spk_wr_val = wr_spk ? {reg_wdata[7:1], 1'b0} : spk_q;
  assign hp_d = hp_clr ? (hp_wr_val & `OPDRV_HP_CLR_MASK)
                       : hp_wr_val;
  assign spk_d = spk_clr ? (spk_wr_val & `OPDRV_SPK_CLR_MASK)
                         : spk_wr_val;

  // read values; live short flags merged into bit 0
  assign hp_rd_val = {hp_q[7:1], hp_short_det};
  assign spk_rd_val = {spk_q[7:1], spk_short_det};
  assign rdata_d = !reg_rd_en ? rdata_q :
                   rd_page ? page_q :
                   rd_err ? err_q :
                   rd_hp ? hp_rd_val :
                   rd_spk ? spk_rd_val :
                   `OPDRV_RD_ZERO;

  // register state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_q <= `OPDRV_PAGE_RST;
      err_q <= `OPDRV_ERR_RST;
      hp_q <= `OPDRV_HP_RST;
      spk_q <= `OPDRV_SPK_RST;
    end else begin
      page_q <= page_d;
      err_q <= err_d;
      hp_q <= hp_d;
      spk_q <= spk_d;
    end
  end

  // read data path
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= `OPDRV_RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= reg_rd_en;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign page_sel = page_q;
  assign left_headphone_driver_en = hp_drv_en[1];
  assign right_headphone_driver_en = hp_drv_en[0];
  assign hp_cm_sel = opdrv_pkg::opdrv_cm_type'(
                       hp_q[`OPDRV_CM_MSB:`OPDRV_CM_LSB]);

  // checks on the bank's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_page_write;
    wr_page |=> page_sel == $past(reg_wdata);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page selector did not take written value");

  property p_rsvd_read;
    reg_rd_en && (page_q == `OPDRV_DRV_PAGE) &&
    (reg_addr >= `OPDRV_RSVD_FIRST) && (reg_addr <= `OPDRV_RSVD_LAST)
    |=> reg_rvalid && reg_rdata == `OPDRV_RD_ZERO;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved register did not read zero");

  property p_spk_clear;
    spk_short_det && !err_q[`OPDRV_SPK_KEEP_BIT]
    |=> !spk_q[`OPDRV_SPK_PWR_BIT];
  endproperty
  a_spk_clear: assert property (p_spk_clear)
    else $error("speaker power-up not cleared on short");

  property p_spk_keep;
    spk_short_det && err_q[`OPDRV_SPK_KEEP_BIT] && !wr_spk
    |=> $stable(spk_q[`OPDRV_SPK_PWR_BIT]);
  endproperty
  a_spk_keep: assert property (p_spk_keep)
    else $error("speaker power-up changed while keep set");

  property p_hp_clear;
    hp_short_det && !err_q[`OPDRV_HP_KEEP_BIT] &&
    hp_q[`OPDRV_HP_PDN_BIT] |=> hp_q[7:6] == 2'b00;
  endproperty
  a_hp_clear: assert property (p_hp_clear)
    else $error("headphone power-up not cleared on short");

  property p_hp_keep;
    hp_short_det && !wr_hp &&
    (err_q[`OPDRV_HP_KEEP_BIT] || !hp_q[`OPDRV_HP_PDN_BIT])
    |=> $stable(hp_q[7:6]);
  endproperty
  a_hp_keep: assert property (p_hp_keep)
    else $error("headphone power-up changed without clear cause");

  // stored bits checked here; a short in the next cycle may gate the pins
  property p_hp_power;
    wr_hp && !hp_short_det |=>
      hp_q[`OPDRV_HPL_BIT] == $past(reg_wdata[7]) &&
      hp_q[`OPDRV_HPR_BIT] == $past(reg_wdata[6]);
  endproperty
  a_hp_power: assert property (p_hp_power)
    else $error("headphone power bits did not follow write");

  // without a short the driver enables show the stored power-up bits
  property p_hp_en;
    !hp_short_det |->
      left_headphone_driver_en == hp_q[`OPDRV_HPL_BIT] &&
      right_headphone_driver_en == hp_q[`OPDRV_HPR_BIT];
  endproperty
  a_hp_en: assert property (p_hp_en)
    else $error("headphone enables differ from power bits");

  property p_spk_en;
    !spk_short_det |-> spk_driver_en == spk_q[`OPDRV_SPK_PWR_BIT];
  endproperty
  a_spk_en: assert property (p_spk_en)
    else $error("speaker enable differs from power bit");

  property p_cm_sel;
    wr_hp |=> hp_cm_sel == opdrv_pkg::opdrv_cm_type'($past(reg_wdata[4:3]));
  endproperty
  a_cm_sel: assert property (p_cm_sel)
    else $error("common-mode select did not follow write");

  property p_short_resp;
    hp_short_det && (|hp_q[7:6]) |->
      (hp_q[`OPDRV_HP_PDN_BIT] ? (hp_drv_en == 2'b00 && !hp_current_limit)
                               : hp_current_limit);
  endproperty
  a_short_resp: assert property (p_short_resp)
    else $error("headphone short response wrong for mode");

  sequence s_rd_hp;
    reg_rd_en && rd_hp;
  endsequence
  property p_hp_flag;
    s_rd_hp |=> reg_rvalid && reg_rdata[0] == $past(hp_short_det) &&
                reg_rdata[7:1] == $past(hp_q[7:1]);
  endproperty
  a_hp_flag: assert property (p_hp_flag)
    else $error("headphone short flag read wrong");

  property p_spk_power;
    wr_spk && !spk_short_det |=> spk_q[7] == $past(reg_wdata[7]);
  endproperty
  a_spk_power: assert property (p_spk_power)
    else $error("speaker power bit did not follow write");

  sequence s_rd_spk;
    reg_rd_en && rd_spk;
  endsequence
  property p_spk_flag;
    s_rd_spk |=> reg_rdata[0] == $past(spk_short_det);
  endproperty
  a_spk_flag: assert property (p_spk_flag)
    else $error("speaker short flag read wrong");

  sequence s_hp_auto_clr;
    hp_clr ##1 (!wr_hp)[*3];
  endsequence
  property p_sticky_clear;
    s_hp_auto_clr |-> hp_q[7:6] == 2'b00;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("auto-cleared headphone bits came back");

endmodule

// *** src/opdrv_short_ctrl.sv ***
// opdrv_short_ctrl: short-circuit response of the headphone and speaker
// drivers; decides automatic power-up clears and driver gating.
// assumes short detect inputs are synchronous to the bank clock.
`timescale 1ns/1ps
module opdrv_short_ctrl (
  input wire logic hp_short_det,
  input wire logic spk_short_det,
  input wire logic hp_keep,
  input wire logic spk_keep,
  input wire logic hp_pdn_mode,
  input wire logic [1:0] hp_pwr,
  input wire logic spk_pwr,
  output logic hp_clr,
  output logic spk_clr,
  output logic [1:0] hp_drv_en,
  output logic spk_drv_en,
  output logic hp_current_limit
);

  // automatic clear requests for the power-up bits
  assign hp_clr = hp_short_det && !hp_keep && hp_pdn_mode;
  assign spk_clr = spk_short_det && !spk_keep;

  // per headphone channel: powered down at once when short and pdn mode
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_hp
      assign hp_drv_en[ch] = hp_pwr[ch] &&
                             !(hp_short_det && hp_pdn_mode);
    end
  endgenerate

  // current limiting applies while a powered headphone driver sees a short with pdn mode off
  assign hp_current_limit = hp_short_det && !hp_pdn_mode &&
                            (|hp_pwr);

  // speaker stays off while an automatic clear is pending
  assign spk_drv_en = spk_pwr && !spk_clr;

endmodule
